/* File: inc/dma_pkg.sv */
// Purpose: Shared constants and types for the four channel block transfer unit.
// Assumes: A 20 MHz system clock, so one tick is 50 ns.
// Notes: Derived cycle counts round a least time up and a longest time down.

package dma_pkg;

  // ****************************************************************
  // Timing figures and their cycle counts
  // ****************************************************************
  localparam int CLK_NS = 50;
  localparam int MEM_CYCLE_NS = 960;
  localparam int BREAK_MIN_NS = 1200;
  localparam int BREAK_OVH_NS = 240;
  localparam int REQ_SETUP_NS = 570;
  localparam int IO_OP_NS = 1920;
  localparam int MAX_IN_NS = 1890;
  localparam int MAX_OUT_NS = 2640;

  // Least times round up to whole ticks.
  localparam int WORD_CYC = (MEM_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int OVH_CYC = (BREAK_OVH_NS + CLK_NS - 1) / CLK_NS;
  localparam int BRK_MIN_CYC = (BREAK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (REQ_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int IO_CYC = (IO_OP_NS + CLK_NS - 1) / CLK_NS;
  // Longest times round down.
  localparam int MAX_IN_CYC = MAX_IN_NS / CLK_NS;
  localparam int MAX_OUT_CYC = MAX_OUT_NS / CLK_NS;

  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int WORD_W = 16;
  localparam int ADDR_W = 15;
  localparam int DIR_BIT = 15;
  localparam int FLAG_BIT = 15;
  localparam int FIFO_W = ADDR_W + WORD_W;
  localparam logic [14:0] FIELD_ONES = 15'h7fff;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] RANGE_RST = 16'h0000;

  // ****************************************************************
  // Instruction codes, channel number in bits 8 to 6
  // ****************************************************************
  localparam logic [15:0] OP_CH_MASK = 16'hfe3f;
  localparam int OP_CH_LSB = 6;
  localparam logic [15:0] OP_LOAD_ADDR = 16'hf014;
  localparam logic [15:0] OP_LOAD_RANGE = 16'hf214;
  localparam logic [15:0] OP_READ_RANGE = 16'hb214;

  // ****************************************************************
  // Transfer sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_OVH = 3'b010,
    ST_XFER = 3'b100
  } xfer_state_e;

endpackage

/* File: inc/fifo_if.sv */
// Purpose: Push and pop handshakes between the sequencer and its word queue.
// Assumes: Both ends run on the same clock.
// Notes: Valid and ready follow the usual rule; a word moves when both are high.

`timescale 1ns/10ps
`default_nettype none

interface fifo_if #(
  parameter int WIDTH = 31
);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;

  // The queue side.
  modport store (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data
  );

  // The sequencer side.
  modport user (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data
  );
endinterface

`default_nettype wire

/* File: rtl/four_channel_block_dma.sv */
// Purpose: Cycle stealing block transfer unit with up to four channels.
// Assumes: cpu_cycle_end_i, io_* and mem_* are on clk_i; device lines are not.
// Notes: Input words pass a queue before their memory write.

`timescale 1ns/10ps
`default_nettype none

module four_channel_block_dma #(
  parameter int NCH = 4,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Processor memory cycle and I/O instructions.
  input wire logic cpu_cycle_end_i,
  input wire logic io_strobe_i,
  input wire logic [15:0] io_code_i,
  input wire logic [15:0] acc_i,
  output logic io_done_o,
  output logic acc_load_o,
  output logic [15:0] acc_o,
  output logic break_o,
  // Devices.
  input wire logic [NCH-1:0] dreq_i,
  input wire logic [15:0] dev_data_i,
  input wire logic auto_switch_i,
  output logic [NCH-1:0] dack_o,
  output logic [15:0] dev_data_o,
  output logic [NCH-1:0] end_of_block_signal_o,
  output logic eot_irq_o,
  // Memory.
  output logic mem_rd_o,
  output logic [14:0] mem_rd_addr_o,
  input wire logic [15:0] mem_rdata_i,
  output logic mem_wr_o,
  output logic [14:0] mem_wr_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic mem_wr_ready_i
);

  localparam int BRK_MIN_A = dma_pkg::BRK_MIN_CYC;
  localparam int LAT_MAX_A = dma_pkg::MAX_IN_CYC;
  localparam int IO_A = dma_pkg::IO_CYC;

  if (NCH < 1 || NCH > 4) begin : g_bad_nch
    $error("four_channel_block_dma supports one to four channels");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Lowest numbered set bit wins, which gives channel 1 precedence.
  function automatic logic [1:0] pick(input logic [NCH-1:0] v);
    logic [1:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  // Returns the channel field when the code matches base and the field names a channel, else zero.
  function automatic logic [2:0] code_ch(input logic [15:0] code, input logic [15:0] base);
    logic [2:0] f;
    f = code[dma_pkg::OP_CH_LSB +: 3];
    return (((code & dma_pkg::OP_CH_MASK) == base) && f != 3'h0 && 32'(f) <= NCH) ? f : 3'h0;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  dma_pkg::xfer_state_e st_q;
  logic [4:0] cnt_q;
  logic [1:0] cur_q;
  logic dir_in_q;
  logic break_q;
  logic [NCH-1:0] req_s1_q, req_s2_q;
  logic [15:0] dat_s1_q, dat_s2_q;
  logic [3:0] age_q [NCH];
  logic [15:0] addr_q [NCH];
  logic [15:0] rc_q [NCH];
  logic [NCH-1:0] eob_q;
  logic act_q, eot_q;
  logic [NCH-1:0] dack_q;
  logic [15:0] dev_data_q;
  logic mem_rd_q, wr_q;
  logic [14:0] rd_addr_q, wr_addr_q;
  logic [15:0] wdata_q;
  logic io_busy_q, io_done_q, acc_load_q;
  logic [5:0] io_cnt_q;
  logic [15:0] acc_q;
  logic [7:0] brk_len_q;

  logic [NCH-1:0] qual, burst_q_v;
  logic grant_any, burst_any, done, ovf;
  logic [1:0] grant_ch, burst_ch, io_ch;
  logic [2:0] la_ch, lr_ch, rr_ch;
  logic io_go;

  fifo_if #(.WIDTH(dma_pkg::FIFO_W)) fq ();

  word_fifo #(.WIDTH(dma_pkg::FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .port(fq.store)
  );

  // ****************************************************************
  // Device line synchronisers
  // ****************************************************************
  // Data is sampled through the same two stages as its request.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      req_s1_q <= '0;
      req_s2_q <= '0;
      dat_s1_q <= '0;
      dat_s2_q <= '0;
    end else begin
      req_s1_q <= dreq_i;
      req_s2_q <= req_s1_q;
      dat_s1_q <= dev_data_i;
      dat_s2_q <= dat_s1_q;
    end
  end

  // ****************************************************************
  // Request qualification and arbitration
  // ****************************************************************
  // In auto-switch mode line 1 feeds whichever of the first two setups is active.
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      logic eff;
      int ln;
      eff = req_s2_q[c];
      ln = c;
      if (auto_switch_i && NCH >= 2 && c < 2) begin
        eff = req_s2_q[0] && (act_q == (c == 1));
        ln = 0;
      end
      // A request counts only after standing the setup time and while the
      // channel is live; input also needs room in the queue.
      qual[c] = eff && (age_q[ln] >= 4'(dma_pkg::SETUP_CYC)) && !eob_q[c]
        && (!addr_q[c][dma_pkg::DIR_BIT] || fq.push_ready);
    end
    burst_q_v = qual & ~(NCH'(1) << cur_q);
  end

  assign grant_any = |qual;
  assign grant_ch = pick(qual);
  assign burst_any = |burst_q_v;
  assign burst_ch = pick(burst_q_v);
  assign done = (st_q == dma_pkg::ST_XFER) && (cnt_q == 5'h00);
  assign ovf = (rc_q[cur_q][14:0] == dma_pkg::FIELD_ONES);

  // Age counts how long each synchronised line has stood; a served line restarts.
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < NCH; l++) begin
      if (sys_rst_i || !req_s2_q[l]) begin
        age_q[l] <= '0;
      end else if (done && ((auto_switch_i && cur_q < 2) ? 0 : int'(cur_q)) == l) begin
        age_q[l] <= '0;
      end else if (age_q[l] < 4'(dma_pkg::SETUP_CYC)) begin
        age_q[l] <= age_q[l] + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Break sequencer
  // ****************************************************************
  // One overhead phase per break, then back to back word slots while requests of channels
  // other than the one just served keep qualifying, so a burst costs the overhead only once.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= dma_pkg::ST_IDLE;
      cnt_q <= '0;
      cur_q <= '0;
      dir_in_q <= 1'b0;
      break_q <= 1'b0;
      mem_rd_q <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      unique case (st_q)
        dma_pkg::ST_IDLE: begin
          if (cpu_cycle_end_i && grant_any) begin
            st_q <= dma_pkg::ST_OVH;
            cnt_q <= 5'(dma_pkg::OVH_CYC - 1);
            cur_q <= grant_ch;
            dir_in_q <= addr_q[grant_ch][dma_pkg::DIR_BIT];
            break_q <= 1'b1;
          end
        end
        dma_pkg::ST_OVH: begin
          if (cnt_q == 5'h00) begin
            st_q <= dma_pkg::ST_XFER;
            cnt_q <= 5'(dma_pkg::WORD_CYC - 1);
            mem_rd_q <= !dir_in_q;
            rd_addr_q <= addr_q[cur_q][14:0];
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        dma_pkg::ST_XFER: begin
          if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
          end else if (burst_any) begin
            cnt_q <= 5'(dma_pkg::WORD_CYC - 1);
            cur_q <= burst_ch;
            dir_in_q <= addr_q[burst_ch][dma_pkg::DIR_BIT];
            mem_rd_q <= !addr_q[burst_ch][dma_pkg::DIR_BIT];
            rd_addr_q <= addr_q[burst_ch][14:0];
          end else begin
            st_q <= dma_pkg::ST_IDLE;
            break_q <= 1'b0;
            mem_rd_q <= 1'b0;
          end
        end
        default: begin
          st_q <= dma_pkg::ST_IDLE;
          break_q <= 1'b0;
          mem_rd_q <= 1'b0;
        end
      endcase
    end
  end

  // Acknowledge and output data appear together at the end of each word slot.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dack_q <= '0;
      dev_data_q <= '0;
    end else begin
      dack_q <= done ? (NCH'(1) << cur_q) : '0;
      if (done && !dir_in_q) begin
        dev_data_q <= mem_rdata_i;
      end
    end
  end

  // ****************************************************************
  // Input queue and memory write port
  // ****************************************************************
  assign fq.push_valid = done && dir_in_q;
  assign fq.push_data = {addr_q[cur_q][14:0], dat_s2_q};
  assign fq.pop_ready = !wr_q || mem_wr_ready_i;

  // Holding register keeps the write port straight from flops.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_q <= 1'b0;
      wr_addr_q <= '0;
      wdata_q <= '0;
    end else if (fq.pop_valid && fq.pop_ready) begin
      wr_q <= 1'b1;
      wr_addr_q <= fq.pop_data[dma_pkg::FIFO_W-1 -: dma_pkg::ADDR_W];
      wdata_q <= fq.pop_data[dma_pkg::WORD_W-1:0];
    end else if (mem_wr_ready_i) begin
      wr_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Channel counters
  // ****************************************************************
  assign la_ch = code_ch(io_code_i, dma_pkg::OP_LOAD_ADDR);
  assign lr_ch = code_ch(io_code_i, dma_pkg::OP_LOAD_RANGE);
  assign rr_ch = code_ch(io_code_i, dma_pkg::OP_READ_RANGE);
  assign io_go = io_strobe_i && !io_busy_q && ((la_ch | lr_ch | rr_ch) != 3'h0);
  assign io_ch = 2'((la_ch | lr_ch | rr_ch) - 3'h1);

  // Address keeps its direction bit; only the 15 address bits advance.
  // A processor load in the same tick overrides the increment.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        addr_q[c] <= dma_pkg::ADDR_RST;
        rc_q[c] <= dma_pkg::RANGE_RST;
      end
    end else begin
      if (done) begin
        addr_q[cur_q][14:0] <= addr_q[cur_q][14:0] + 15'h0001;
        rc_q[cur_q][14:0] <= rc_q[cur_q][14:0] + 15'h0001;
      end
      if (io_go && la_ch != 3'h0) begin
        addr_q[io_ch] <= acc_i;
        rc_q[io_ch] <= dma_pkg::RANGE_RST;
      end
      if (io_go && lr_ch != 3'h0) begin
        rc_q[io_ch][14:0] <= rc_q[io_ch][14:0] | acc_i[14:0];
      end
    end
  end

  // Channels start ended so nothing moves before software sets them up;
  // an overflow in the same tick as a reload still ends the block.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      eob_q <= '1;
    end else begin
      if (io_go && la_ch != 3'h0) begin
        eob_q[io_ch] <= 1'b0;
      end
      if (done && ovf) begin
        eob_q[cur_q] <= 1'b1;
      end
    end
  end

  // Auto-switch flips the active setup in the slot that ends the block.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      act_q <= 1'b0;
      eot_q <= 1'b0;
    end else if (done && ovf && auto_switch_i && NCH >= 2 && cur_q < 2) begin
      act_q <= !act_q;
      eot_q <= 1'b1;
    end else begin
      eot_q <= 1'b0;
    end
  end

  // ****************************************************************
  // I/O instruction timing and read-back
  // ****************************************************************
  // Effects land at the strobe; completion is reported after two memory cycles.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      io_busy_q <= 1'b0;
      io_cnt_q <= '0;
      io_done_q <= 1'b0;
      acc_load_q <= 1'b0;
      acc_q <= '0;
    end else begin
      io_done_q <= 1'b0;
      if (io_go) begin
        io_busy_q <= 1'b1;
        io_cnt_q <= 6'(dma_pkg::IO_CYC - 1);
        acc_load_q <= (rr_ch != 3'h0) && !eob_q[io_ch];
        acc_q <= {1'b1, rc_q[io_ch][14:0]};
      end else if (io_busy_q && io_cnt_q == 6'h00) begin
        io_busy_q <= 1'b0;
        io_done_q <= 1'b1;
      end else if (io_busy_q) begin
        io_cnt_q <= io_cnt_q - 6'h01;
      end
    end
  end

  // Length of the current break, read only by the checks below.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !break_q) begin
      brk_len_q <= '0;
    end else if (brk_len_q != 8'hff) begin
      brk_len_q <= brk_len_q + 8'h01;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_break_min_len: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(break_q) |-> brk_len_q >= 8'(BRK_MIN_A)) else $error("break shorter than minimum");
  a_take_cycle_end: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(break_q) |-> $past(cpu_cycle_end_i) && $past(grant_any)) else $error("break not at cycle end");
  a_ch1_first: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st_q == dma_pkg::ST_IDLE && cpu_cycle_end_i && qual[0]) |=> cur_q == 2'd0)
    else $error("channel 1 lost arbitration");
  a_word_latency: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(break_q) |-> ##[1:LAT_MAX_A] done) else $error("word not done in time");
  a_ended_no_grant: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    done |-> !eob_q[cur_q])
    else $error("word moved on an ended channel");
  a_overflow_ends: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (done && ovf) |=> eob_q[$past(cur_q)] && end_of_block_signal_o[$past(cur_q)])
    else $error("overflow did not end block");
  a_range_step: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (done && !io_go) |=> rc_q[$past(cur_q)][14:0] == $past(rc_q[cur_q][14:0]) + 15'h0001)
    else $error("range counter did not advance");
  a_load_addr_eff: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (io_go && la_ch != 3'h0) |=> addr_q[$past(io_ch)] == $past(acc_i) && rc_q[$past(io_ch)] == 16'h0000)
    else $error("load address wrong");
  a_io_two_cycles: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    io_go |=> !io_done_o ##IO_A io_done_o) else $error("instruction timing wrong");
  a_read_at_end: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (io_go && rr_ch != 3'h0 && eob_q[io_ch]) |=> !acc_load_q) else $error("read range not a no-op");
  a_switch_irq: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (done && ovf && auto_switch_i && cur_q < 2) |=> eot_irq_o && act_q != $past(act_q))
    else $error("auto-switch missed");

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign io_done_o = io_done_q;
  assign acc_load_o = acc_load_q;
  assign acc_o = acc_q;
  assign break_o = break_q;
  assign dack_o = dack_q;
  assign dev_data_o = dev_data_q;
  assign end_of_block_signal_o = eob_q;
  assign eot_irq_o = eot_q;
  assign mem_rd_o = mem_rd_q;
  assign mem_rd_addr_o = rd_addr_q;
  assign mem_wr_o = wr_q;
  assign mem_wr_addr_o = wr_addr_q;
  assign mem_wdata_o = wdata_q;

endmodule

`default_nettype wire

/* File: rtl/word_fifo.sv */
// Purpose: Queue of input words waiting for a memory write slot.
// Assumes: Depth is a power of two, at least two.
// Notes: Pointers carry one extra bit so full and empty are told apart.

`timescale 1ns/10ps
`default_nettype none

module word_fifo #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Queue handshakes.
  fifo_if.store port
);

  localparam int PW = $clog2(DEPTH);

  // ****************************************************************
  // Storage and pointers
  // ****************************************************************
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0] wr_q;
  logic [PW:0] rd_q;
  logic push_go;
  logic pop_go;

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("word_fifo depth must be a power of two of at least two");
  end

  // Full when the pointers differ only in their top bit.
  assign port.push_ready = (wr_q[PW] == rd_q[PW]) || (wr_q[PW-1:0] != rd_q[PW-1:0]);
  assign port.pop_valid = (wr_q != rd_q);
  assign port.pop_data = mem_q[rd_q[PW-1:0]];
  assign push_go = port.push_valid && port.push_ready;
  assign pop_go = port.pop_valid && port.pop_ready;

  // Write side.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_q <= '0;
    end else if (push_go) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  // Storage is not reset; only words behind the write pointer are read.
  always_ff @(posedge clk_i) begin
    if (push_go) begin
      mem_q[wr_q[PW-1:0]] <= port.push_data;
    end
  end

  // Read side.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_q <= '0;
    end else if (pop_go) begin
      rd_q <= rd_q + 1'b1;
    end
  end

endmodule

`default_nettype wire

/* File: verification/dev_mem_model.sv */
// Purpose: Device and memory stand-in for the block transfer unit.
// Assumes: One clock; a memory cycle ends every 20 ticks.
// Notes: Write ready comes one tick in four, so a held write waits up to four ticks.
`timescale 1ns/10ps
`default_nettype none
module dev_mem_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Device side.
  input wire logic [3:0] want_i,
  input wire logic [3:0] dack_i,
  output logic [3:0] dreq_o,
  output logic cyc_end_o,
  // Memory side.
  input wire logic mem_rd_i,
  input wire logic [14:0] mem_rd_addr_i,
  output logic [15:0] mem_rdata_o,
  output logic mem_wr_ready_o
);
  // ****************************************************************
  // Memory cycle and device requests
  // ****************************************************************
  logic [4:0] tick_q;
  // Processor work halts during a break; only memory cycles keep ticking.
  always_ff @(posedge clk_i) begin
    tick_q <= (sys_rst_i || tick_q == 5'd19) ? 5'd0 : tick_q + 5'd1;
  end
  assign cyc_end_o = (tick_q == 5'd19);
  assign mem_wr_ready_o = (tick_q[1:0] == 2'b11);
  // Released read data changes every tick so a stale word cannot pass.
  assign mem_rdata_o = mem_rd_i ? ({1'b0, mem_rd_addr_i} ^ 16'ha5a5) : {11'd0, tick_q};
  // A request stands from well before the cycle end until its acknowledge.
  always_ff @(posedge clk_i) begin
    dreq_o <= sys_rst_i ? 4'h0 : (dreq_o | want_i) & ~dack_i;
  end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Purpose: Self-checking bench for the four channel block transfer unit.
// Assumes: 50 ns clock; inputs change at the falling edge.
// Notes: Instruction rows run first, then transfers, end of range and reload.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t mismatch %h vs %h", $time, (a), (b)); end end
module testbench;
  // ****************************************************************
  // Signals, rows and instances
  // ****************************************************************
  typedef struct {logic [15:0] code; logic [15:0] acc; logic load; logic [15:0] res;} row_s;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic io_strobe_i = 1'b0;
  logic [15:0] io_code_i = 16'h0000;
  logic [15:0] acc_i = 16'h0000;
  logic [15:0] dev_data_i = 16'h1234;
  logic [3:0] want = 4'h0;
  logic [3:0] first_ack = 4'h0;
  logic auto_sw = 1'b0;
  logic cyc_end, io_done_o, acc_load_o, break_o, eot_irq_o, mem_rd_o, mem_wr_o, mem_wr_ready;
  logic [15:0] acc_o, dev_data_o, mem_rdata, mem_wdata_o, last_out, wdata;
  logic [14:0] mem_rd_addr_o, mem_wr_addr_o, waddr;
  logic [3:0] dreq, dack_o, eob;
  int num_errors = 0;
  int cmp_count = 0;
  int n0 = 0;
  int n1 = 0;
  int n_eot = 0;
  int n;
  // Code, accumulator, expected load flag and result.
  row_s rows [6] = '{'{16'hf054, 16'h0010, 1'b0, 16'h0000}, '{16'hf254, 16'hfffe, 1'b0, 16'h0000},
    '{16'hb254, 16'h0000, 1'b1, 16'hfffe}, '{16'hf094, 16'h8020, 1'b0, 16'h0000},
    '{16'hf294, 16'hffff, 1'b0, 16'h0000}, '{16'hb2d4, 16'h0000, 1'b0, 16'h0000}};
  four_channel_block_dma uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cpu_cycle_end_i(cyc_end),
    .io_strobe_i(io_strobe_i), .io_code_i(io_code_i), .acc_i(acc_i), .io_done_o(io_done_o),
    .acc_load_o(acc_load_o), .acc_o(acc_o), .break_o(break_o), .dreq_i(dreq),
    .dev_data_i(dev_data_i), .auto_switch_i(auto_sw), .dack_o(dack_o), .dev_data_o(dev_data_o),
    .end_of_block_signal_o(eob), .eot_irq_o(eot_irq_o), .mem_rd_o(mem_rd_o),
    .mem_rd_addr_o(mem_rd_addr_o), .mem_rdata_i(mem_rdata), .mem_wr_o(mem_wr_o),
    .mem_wr_addr_o(mem_wr_addr_o), .mem_wdata_o(mem_wdata_o), .mem_wr_ready_i(mem_wr_ready));
  dev_mem_model partner (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .want_i(want), .dack_i(dack_o),
    .dreq_o(dreq), .cyc_end_o(cyc_end), .mem_rd_i(mem_rd_o), .mem_rd_addr_i(mem_rd_addr_o),
    .mem_rdata_o(mem_rdata), .mem_wr_ready_o(mem_wr_ready));
  // Clock at 20 MHz.
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // Acknowledges, output words and accepted writes are recorded as they happen.
  always @(posedge clk_i) begin
    if (dack_o[0] === 1'b1) begin
      n0++;
      last_out = dev_data_o;
    end
    if (dack_o[1] === 1'b1) n1++;
    if (eot_irq_o === 1'b1) n_eot++;
    if (dack_o !== 4'h0 && first_ack === 4'h0) first_ack = dack_o;
    if (mem_wr_o === 1'b1 && mem_wr_ready === 1'b1) begin
      waddr = mem_wr_addr_o;
      wdata = mem_wdata_o;
    end
  end
  // One instruction; the strobe stands a single tick, done is timed.
  task automatic do_io(input logic [15:0] c, input logic [15:0] a);
    @(negedge clk_i);
    io_strobe_i = 1'b1;
    io_code_i = c;
    acc_i = a;
    @(negedge clk_i);
    io_strobe_i = 1'b0;
    n = 0;
    while (io_done_o !== 1'b1 && n < 60) begin
      @(negedge clk_i);
      n++;
    end
    `CHK(n, 39)
  endtask
  task automatic wrap_up;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // A hang stops the run well after the tests would have ended.
  initial begin
    #(50 * 20000);
    num_errors++;
    wrap_up();
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk_i);
    @(negedge clk_i) sys_rst_i = 1'b0;
    `CHK(eob, 4'hf)
    `CHK(break_o, 1'b0)
    for (int i = 0; i < 6; i++) begin
      do_io(rows[i].code, rows[i].acc);
      `CHK(acc_load_o, rows[i].load)
      if (rows[i].load) `CHK(acc_o, rows[i].res)
    end
    `CHK(eob, 4'b1100)
    $display("instruction table done");
    // Channel 1 outputs two words, channel 2 inputs one, both asking at once.
    want = 4'b0011;
    n = 0;
    while (eob !== 4'hf && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    repeat (20) @(negedge clk_i);
    `CHK(first_ack, 4'b0001)
    `CHK(n0, 2)
    `CHK(n1, 1)
    `CHK(last_out, 16'h0011 ^ 16'ha5a5)
    `CHK(waddr, 15'h0020)
    `CHK(wdata, 16'h1234)
    repeat (200) @(negedge clk_i);
    `CHK(n0, 2)
    do_io(16'hb254, 16'h0000);
    `CHK(acc_load_o, 1'b0)
    $display("transfer test done");
    // The request still pending on channel 1 is served once it is reloaded.
    want = 4'h0;
    do_io(16'hf054, 16'h0030);
    `CHK(eob[0], 1'b0)
    n = 0;
    while (n0 < 3 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    `CHK(n0, 3)
    `CHK(last_out, 16'h0030 ^ 16'ha5a5)
    do_io(16'hb254, 16'h0000);
    `CHK(acc_o, 16'h8001)
    $display("reload test done");
    // Auto-switch: line 1 serves channel 1's setup, then channel 2's, one word each.
    auto_sw = 1'b1;
    do_io(16'hf054, 16'h0040);
    do_io(16'hf254, 16'hffff);
    do_io(16'hf094, 16'h0050);
    do_io(16'hf294, 16'hffff);
    want = 4'b0001;
    n = 0;
    while (eob !== 4'hf && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    repeat (20) @(negedge clk_i);
    `CHK(n_eot, 2)
    `CHK(n0, 4)
    `CHK(n1, 2)
    `CHK(dev_data_o, 16'h0050 ^ 16'ha5a5)
    $display("auto-switch test done");
    // A reset in mid-run ends every channel and clears the read-back.
    sys_rst_i = 1'b1;
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    @(negedge clk_i);
    `CHK(eob, 4'hf)
    `CHK(acc_load_o, 1'b0)
    `CHK(break_o, 1'b0)
    $display("reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire
